//--- core/sbp_pkg.sv
/*
 * constants, field positions and carrier types for the sram bank controller
 * assumes apb with a 12-bit offset window and a 32-bit system bus port
 */
package sbp_pkg;
	// apb register offsets
	localparam logic [11:0] CFG_OFS         = 12'h000;
	localparam logic [11:0] INIT_STAT_OFS   = 12'h004;
	localparam logic [11:0] CACHE_STATE_OFS = 12'h058;
	localparam logic [11:0] CACHE_SETUP_OFS = 12'h05c;
	localparam logic [11:0] CACHE_KEY_OFS   = 12'h060;

	// config register fields
	localparam int MODE_BIT  = 31;
	localparam int ABORT_BIT = 15;
	localparam int AUTO_BIT  = 14;
	localparam int START_BIT = 13;
	localparam int RET1_BIT  = 1;
	localparam int RET2_BIT  = 2;
	localparam int NBANK     = 6;
	localparam int CACHE_BANK = 5;

	// reset values
	localparam logic       MODE_RST      = 1'b1;
	localparam logic [5:0] PAR_EN_RST    = 6'h3f;
	localparam logic       AUTO_RST      = 1'b0;
	localparam logic [5:0] INIT_DONE_RST = 6'h00;
	localparam logic [5:0] BOOT_INIT_SEL = 6'h01;
	localparam logic [31:0] CACHE_KEY    = 32'hf123f456;

	// init sequence length in bus clock cycles
	localparam int         INIT_CYCLES = 1024;
	localparam logic [9:0] INIT_LAST   = 10'(INIT_CYCLES - 1);

	// address map
	localparam int          MEM_WORDS   = 16384;
	localparam logic [31:0] INSTR_BASE  = 32'h1000_0000;
	localparam logic [31:0] DATA0_BASE  = 32'h2000_0000;
	localparam logic [31:0] DATA1_BASE  = 32'h2004_0000;
	localparam logic [31:0] SPAN_FULL   = 32'h0000_8000;
	localparam logic [31:0] SPAN_HALF   = 32'h0000_4000;
	localparam logic [13:0] INSTR_W_LO  = 14'h1000;
	localparam logic [13:0] INSTR_W_HI  = 14'h3000;
	localparam logic [13:0] DATA1_W     = 14'h2000;
	localparam logic [5:0][13:0] BANK_BASE =
		{14'h3c00, 14'h3000, 14'h2000, 14'h1000, 14'h0800, 14'h0000};
	// words cleared per init cycle, bank size over the init length
	localparam logic [5:0][2:0] BANK_WPC =
		{3'h1, 3'h3, 3'h4, 3'h4, 3'h2, 3'h2};
	localparam logic [1:0] SIZE_WORD = 2'h2;

	typedef enum logic {
		INIT_IDLE = 1'b0,
		INIT_RUN  = 1'b1
	} sbp_init_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} sbp_bus_req_s;

	typedef struct packed {
		logic        ready;
		logic        error;
		logic [31:0] rdata;
	} sbp_bus_rsp_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [9:0]  index;
		logic [31:0] wdata;
	} sbp_cache_req_s;

	typedef struct packed {
		logic        hit;
		logic [2:0]  bank;
		logic [13:0] word;
	} sbp_map_s;
endpackage : sbp_pkg

//--- core/sbp_parity.sv
/*
 * two parity bits for one 32-bit word, one per half word
 * purely combinational, used on both old and new sram words
 */
`timescale 1ns/100ps
module sbp_parity (
	input  wire logic [31:0] word, // data word
	output logic      [1:0]  par   // {upper, lower} even parity
);
	// a split parity catches two flips when they land in different halves
	assign par = {^word[31:16], ^word[15:0]};
endmodule : sbp_parity

//--- core/sbp_ctrl.sv
/*
 * sram bank controller: mode mapping, retention select, parity, bank init
 * sequencer and the cache enable registers behind apb.
 * assumes a system bus master that holds its request until ready, and a
 * power controller giving a one-cycle hibernate exit pulse on this clock.
 */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/100ps
module sbp_ctrl (
	input  wire logic                   clock,       // bus clock
	input  wire logic                   rstn,        // async reset, low
	input  wire logic [11:0]            paddr,       // apb offset
	input  wire logic                   psel,        // apb select
	input  wire logic                   penable,     // apb enable
	input  wire logic                   pwrite,      // apb direction
	input  wire logic [31:0]            pwdata,      // apb write data
	output logic      [31:0]            prdata,      // apb read data
	output logic                        pready,      // apb ready
	output logic                        pslverr,     // apb error
	input  wire sbp_pkg::sbp_bus_req_s  bus_req,     // system bus request
	output sbp_pkg::sbp_bus_rsp_s       bus_rsp,     // system bus answer
	input  wire sbp_pkg::sbp_cache_req_s cache_req,  // cache word port
	output logic      [31:0]            cache_rdata, // cache read word
	input  wire logic                   hib_exit,    // hibernate exit pulse
	output logic      [5:0]             bank_retain, // per-bank retention
	output logic                        icache_on    // cache enabled
);
	import sbp_pkg::*;

	////////////////////////////////////////////////////////////////////
	// functions

	// word index to bank number
	function automatic logic [2:0] bank_of(input logic [13:0] w);
		logic [2:0] b;
		b = 3'h0;
		case (w[13:11])
			3'h0: b = 3'h0;
			3'h1: b = 3'h1;
			3'h2, 3'h3: b = 3'h2;
			3'h4, 3'h5: b = 3'h3;
			3'h6: b = 3'h4;
			3'h7: b = w[10] ? 3'h5 : 3'h4;
			default: b = 3'h0;
		endcase
		return b;
	endfunction : bank_of

	// byte address to bank and word under the current mode
	function automatic sbp_map_s map_addr(input logic [31:0] a,
		input logic instr, input logic cache);
		sbp_map_s   m;
		logic [31:0] span;
		logic [31:0] off;
		m = '0;
		span = instr ? SPAN_HALF : SPAN_FULL;
		off = 32'h0;
		if (a >= DATA0_BASE && a < DATA0_BASE + span) begin
			off = a - DATA0_BASE;
			m.hit = 1'b1;
			m.word = off[15:2];
		end else if (a >= DATA1_BASE && a < DATA1_BASE + span) begin
			off = a - DATA1_BASE;
			m.hit = 1'b1;
			m.word = DATA1_W + off[15:2];
		end else if (instr && a >= INSTR_BASE && a < INSTR_BASE + SPAN_FULL) begin
			// two 16 kB regions: bank 2, then banks 4 and 5
			off = a - INSTR_BASE;
			m.hit = 1'b1;
			if (off < SPAN_HALF) begin
				m.word = INSTR_W_LO + off[15:2];
			end else begin
				m.word = INSTR_W_HI + 14'(off[15:2] - 14'h1000);
			end
		end
		m.bank = bank_of(m.word);
		if (cache && m.bank == 3'(CACHE_BANK)) begin
			m.hit = 1'b0;
		end
		return m;
	endfunction : map_addr

	// byte lanes touched by a transfer
	function automatic logic [3:0] lanes(input logic [1:0] size,
		input logic [1:0] a);
		logic [3:0] l;
		case (size)
			2'h0: l = 4'h1 << a;
			2'h1: l = a[1] ? 4'hc : 4'h3;
			default: l = 4'hf;
		endcase
		return l;
	endfunction : lanes

	////////////////////////////////////////////////////////////////////
	// state

	logic [33:0] mem [0:MEM_WORDS-1];
	logic        mode;
	logic [5:0]  par_en;
	logic        auto_init;
	logic        cache_en;
	logic        key_ok;
	sbp_init_e   init_state;
	logic [9:0]  init_cnt;
	logic [5:0]  init_sel;
	logic [5:0]  init_done;

	////////////////////////////////////////////////////////////////////
	// apb decode

	wire         apb_access = psel & penable & ~pready;
	wire         apb_commit = psel & penable & pready & pwrite;
	wire         hit_cfg    = paddr == CFG_OFS;
	wire         hit_stat   = paddr == INIT_STAT_OFS;
	wire         hit_cstate = paddr == CACHE_STATE_OFS;
	wire         hit_setup  = paddr == CACHE_SETUP_OFS;
	wire         hit_key    = paddr == CACHE_KEY_OFS;
	wire         reg_hit    = hit_cfg | hit_stat | hit_cstate | hit_setup | hit_key;
	wire         cfg_wr     = apb_commit & hit_cfg;
	wire         setup_wr   = apb_commit & hit_setup & key_ok;
	wire         key_wr     = apb_commit & hit_key;
	// start and abort strobes are never stored, so they read back as zero
	wire [31:0]  cfg_view   = {mode, 16'h0, auto_init, 7'h0, 1'h0, par_en};
	wire [31:0]  rd_value   = hit_cfg    ? cfg_view :
	                          hit_stat   ? {26'h0, init_done} :
	                          hit_cstate ? {31'h0, icache_on} :
	                          hit_setup  ? {31'h0, cache_en} :
	                          32'h0; // key reads zero
	// only an offset outside the map is refused; writes to read-only ones are dropped
	wire         rd_bad     = ~reg_hit;

	// answer one cycle after the access phase opens
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_access;
			prdata  <= (apb_access & ~pwrite) ? rd_value : 32'h0;
			pslverr <= apb_access & rd_bad;
		end
	end

	////////////////////////////////////////////////////////////////////
	// config and cache registers

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode      <= MODE_RST;
			par_en    <= PAR_EN_RST;
			auto_init <= AUTO_RST;
		end else if (cfg_wr) begin
			mode      <= pwdata[MODE_BIT];
			par_en    <= pwdata[5:0];
			auto_init <= pwdata[AUTO_BIT];
		end
	end

	// key arms one setup write; the setup write always drops it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			key_ok    <= 1'b0;
			cache_en  <= 1'b0;
			icache_on <= 1'b0;
		end else begin
			if (apb_commit & hit_setup) begin
				key_ok <= 1'b0;
			end else if (key_wr) begin
				key_ok <= pwdata == CACHE_KEY;
			end
			if (setup_wr) begin
				cache_en <= pwdata[0];
			end
			icache_on <= cache_en;
		end
	end

	// bank 0 always kept, banks 3 to 5 never
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bank_retain <= {3'h0, PAR_EN_RST[RET2_BIT], PAR_EN_RST[RET1_BIT], 1'b1};
		end else begin
			bank_retain <= {3'h0, par_en[RET2_BIT], par_en[RET1_BIT], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////
	// init sequencer

	wire [5:0]  sel_src    = cfg_wr ? pwdata[5:0] : par_en;
	// a cache-owned bank is skipped so live cache lines are not cleared
	wire [5:0]  start_sel  = sel_src & ~(6'(cache_en) << CACHE_BANK);
	wire        start_req  = (cfg_wr & pwdata[START_BIT]) | (hib_exit & auto_init);
	wire        abort_req  = cfg_wr & pwdata[ABORT_BIT];
	wire        init_run   = init_state == INIT_RUN;
	wire        init_fin   = init_run & (init_cnt == INIT_LAST);

	// reset enters the run state on bank 0 so the stack is clean
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			init_state <= INIT_RUN;
			init_cnt   <= 10'h0;
			init_sel   <= BOOT_INIT_SEL;
		end else if (abort_req) begin
			init_state <= INIT_IDLE;
			init_sel   <= 6'h0;
		end else if (start_req) begin
			init_state <= INIT_RUN;
			init_cnt   <= 10'h0;
			init_sel   <= start_sel;
		end else begin
			case (init_state)
				INIT_RUN: begin
					init_cnt <= init_cnt + 10'h1;
					if (init_fin) begin
						init_state <= INIT_IDLE;
						init_sel   <= 6'h0;
					end
				end
				default: init_cnt <= 10'h0;
			endcase
		end
	end

	// done bits: start clears, completion sets; abort leaves them low
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			init_done <= INIT_DONE_RST;
		end else if (start_req & ~abort_req) begin
			init_done <= init_done & ~start_sel;
		end else if (init_fin & ~abort_req) begin
			init_done <= init_done | init_sel;
		end
	end

	////////////////////////////////////////////////////////////////////
	// system bus path

	sbp_map_s    bmap;
	logic [33:0] old_word;
	logic [1:0]  old_par;
	logic [1:0]  new_par;
	logic [1:0]  cache_par;
	logic [31:0] merged;

	assign bmap     = map_addr(bus_req.addr, mode, cache_en);
	assign old_word = mem[bmap.word];

	wire [3:0]  lane_en   = lanes(bus_req.size, bus_req.addr[1:0]);
	wire        bus_stall = init_run & bmap.hit & init_sel[bmap.bank];
	wire        bus_take  = bus_req.valid & ~bus_rsp.ready & ~bus_stall;
	wire        full_wr   = bus_req.write & (bus_req.size == SIZE_WORD);
	wire        par_bad   = par_en[bmap.bank] & ~full_wr & (old_par != old_word[33:32]);
	wire        bus_err   = ~bmap.hit | par_bad;

	// merge the new bytes over the stored word
	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_lane
			assign merged[8*gl +: 8] = lane_en[gl] ?
				bus_req.wdata[8*gl +: 8] : old_word[8*gl +: 8];
		end
	endgenerate

	sbp_parity u_old_par (
		.word (old_word[31:0]),
		.par  (old_par)
	);

	sbp_parity u_new_par (
		.word (merged),
		.par  (new_par)
	);

	sbp_parity u_cache_par (
		.word (cache_req.wdata),
		.par  (cache_par)
	);

	// one answer per request; ready blocks a second take of the same one
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bus_rsp <= '0;
		end else begin
			bus_rsp.ready <= bus_take;
			bus_rsp.error <= bus_take & bus_err;
			bus_rsp.rdata <= (bus_take & bmap.hit & ~bus_req.write) ?
				old_word[31:0] : 32'h0;
		end
	end

	// cache word reads, only while the cache owns bank 5
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cache_rdata <= 32'h0;
		end else if (cache_en & cache_req.valid & ~cache_req.write) begin
			cache_rdata <= mem[BANK_BASE[CACHE_BANK] + 14'(cache_req.index)][31:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// sram array writes; bus never meets init or cache on one word, but cache and init writes can meet in bank 5

	always_ff @(posedge clock) begin
		if (bus_take & bmap.hit & bus_req.write) begin
			mem[bmap.word] <= {new_par, merged};
		end
		if (cache_en & cache_req.valid & cache_req.write) begin
			mem[BANK_BASE[CACHE_BANK] + 14'(cache_req.index)] <=
				{cache_par, cache_req.wdata};
		end
		for (int b = 0; b < NBANK; b++) begin
			for (int j = 0; j < 4; j++) begin
				if (init_run && init_sel[b] && j < int'(BANK_WPC[b])) begin
					// widen before the product, every bank but bank 5 runs past ten bits
					mem[BANK_BASE[b] + 14'(init_cnt) * 14'(BANK_WPC[b]) + 14'(j)] <=
						34'h0;
				end
			end
		end
	end
endmodule : sbp_ctrl

//--- testbench/sbp_properties.sv
/* checker for the sram bank controller ports
   assumes one bus clock and rstn low as reset */
`timescale 1ns/100ps
module sbp_chk
	import sbp_pkg::*;
(
	input wire logic           clock,
	input wire logic           rstn,
	input wire logic [11:0]    paddr,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [31:0]    pwdata,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	input wire sbp_bus_req_s   bus_req,
	input wire sbp_bus_rsp_s   bus_rsp,
	input wire sbp_cache_req_s cache_req,
	input wire logic [31:0]    cache_rdata,
	input wire logic           hib_exit,
	input wire logic [5:0]     bank_retain,
	input wire logic           icache_on
);
	logic [10:0] age;
	// address classes, a held request still shows its address with ready
	wire rd_cfg = pready && !pwrite && paddr == CFG_OFS;
	wire b5     = bus_req.addr[31:12] == 20'h10007 || bus_req.addr[31:12] == 20'h20047;
	wire b0     = bus_req.addr[31:13] == 19'h10000;
	// cycles since reset, saturating so it never wraps into the boot window
	always_ff @(posedge clock or negedge rstn)
		if (!rstn) age <= '0;
		else if (age != 11'h7ff) age <= age + 11'h1;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	apb_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	rsp_pulse_a: assert property (bus_rsp.ready |=> !bus_rsp.ready)
		else $error("bus ready longer than one cycle");
	retain_fixed_a: assert property (bank_retain[0] && bank_retain[5:3] == 3'h0)
		else $error("fixed retention wrong");
	retain_cfg_a: assert property (rd_cfg |-> prdata[2:1] == bank_retain[2:1])
		else $error("retention not from config");
	cfg_selfclr_a: assert property (rd_cfg |-> !prdata[15] && !prdata[13])
		else $error("start or abort reads one");
	key_zero_a: assert property (pready && !pwrite && paddr == CACHE_KEY_OFS |-> prdata == '0)
		else $error("key reads nonzero");
	bank5_err_a: assert property (bus_rsp.ready && icache_on && $past(icache_on) && b5
		|-> bus_rsp.error)
		else $error("cache bank reachable");
	word_wr_a: assert property (bus_rsp.ready && bus_req.write && bus_req.size == SIZE_WORD
		&& b0 |-> !bus_rsp.error)
		else $error("word write flagged");
	boot_stall_a: assert property (age < 11'd1000 |-> !(bus_rsp.ready && b0))
		else $error("bank 0 served during boot init");
	cache_off_a: assert property (age < 11'd8 |-> !icache_on)
		else $error("cache on after reset");
	cov_err_c: cover property (bus_rsp.ready && bus_rsp.error);
	cov_slv_c: cover property (pready && pslverr);
	cov_cache_c: cover property ($rose(icache_on));
endmodule : sbp_chk

bind sbp_ctrl sbp_chk sbp_chk_inst (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .bus_req(bus_req), .bus_rsp(bus_rsp), .cache_req(cache_req),
	.cache_rdata(cache_rdata), .hib_exit(hib_exit), .bank_retain(bank_retain),
	.icache_on(icache_on));

//--- testbench/sbp_master.sv
/* system bus master model facing the controller
   assumes ready is a one-cycle pulse sampled at a rising edge */
`timescale 1ns/100ps
module sbp_master
	import sbp_pkg::*;
(
	input  wire logic         clock,   // bus clock
	output sbp_bus_req_s      bus_req, // request
	input  wire sbp_bus_rsp_s bus_rsp  // answer
);
	initial bus_req = '0;
	////////////////////////////////////////
	// one transfer held until ready; n counts edges, 3000 means gave up
	task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] a, d,
		output logic [31:0] q, output logic er, output int n);
		n = 0;
		@(posedge clock);
		bus_req <= '{1'b1, wr, sz, a, d};
		do begin
			@(posedge clock);
			n++;
		end while (bus_rsp.ready !== 1'b1 && n < 3000);
		q = bus_rsp.rdata;
		er = bus_rsp.error;
		// released lines turn over so nothing stale looks valid
		bus_req <= '{1'b0, ~wr, sz, ~a, ~d};
	endtask : xfer
endmodule : sbp_master

//--- testbench/tb.sv
/* bench for the sram bank controller: apb and system bus sequences
   assumes sbp_master as bus partner and the bound checker */
`timescale 1ns/100ps
module tb;
	import sbp_pkg::*;
	logic           clock = 1'b0, rstn = 1'b0, hib_exit = 1'b0;
	logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]    paddr = '0;
	logic [31:0]    pwdata = '0, prdata, cache_rdata, q;
	logic           pready, pslverr, icache_on, e;
	logic [5:0]     bank_retain;
	sbp_bus_req_s   bus_req;
	sbp_bus_rsp_s   bus_rsp;
	sbp_cache_req_s cache_req = '0;
	int             err_count = 0, n_checks = 0, n;

	sbp_ctrl sbp_ctrl_inst (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_req(bus_req), .bus_rsp(bus_rsp),
		.cache_req(cache_req), .cache_rdata(cache_rdata), .hib_exit(hib_exit),
		.bank_retain(bank_retain), .icache_on(icache_on));
	sbp_master sbp_master_inst (.clock(clock), .bus_req(bus_req), .bus_rsp(bus_rsp));

	// 200 MHz bus clock
	initial begin
		forever #2.5 clock = ~clock;
	end
	////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrap_up();
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	// apb transfer, request held until pready seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			err_count++;
			wrap_up();
		end
	endtask : apb
	task automatic sb(input logic wr, input logic [1:0] sz, input logic [31:0] a, d);
		sbp_master_inst.xfer(wr, sz, a, d, q, e, n);
		if (n >= 3000) begin
			err_count++;
			wrap_up();
		end
	endtask : sb
	task automatic st(input logic [31:0] exp);
		apb(1'b0, INIT_STAT_OFS, '0);
		chk("init status", q, exp);
	endtask : st
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		chk("retain", {26'h0, bank_retain}, 32'h7);
		chk("cache on", {31'h0, icache_on}, 32'h0);
		apb(1'b0, CFG_OFS, '0);
		chk("config", q, 32'h8000_003f);
		st(32'h0);
		// bank 1 is outside the boot init so it answers at once
		sb(1'b1, SIZE_WORD, 32'h2000_2000, 32'h1234_5678);
		chk("bank1 latency", 32'(n), 32'd2);
		sb(1'b1, 2'h0, 32'h2000_2001, 32'h0000_ab00);
		sb(1'b0, SIZE_WORD, 32'h2000_2000, '0);
		chk("byte merge", q, 32'h1234_ab78);
		chk("word read err", {31'h0, e}, 32'h0);
		sb(1'b1, SIZE_WORD, 32'h2000_0010, 32'h5);
		chk("bank0 stall", {31'h0, n > 900}, 32'h1);
		st(32'h1);
		sb(1'b0, SIZE_WORD, 32'h2004_4000, '0);
		chk("instr gap err", {31'h0, e}, 32'h1);
		sb(1'b1, SIZE_WORD, 32'h1000_4000, 32'h77);
		sb(1'b0, SIZE_WORD, 32'h1000_4000, '0);
		chk("instr data", q, 32'h77);
		// data mode, parity off everywhere
		apb(1'b1, CFG_OFS, 32'h0);
		sb(1'b1, SIZE_WORD, 32'h2004_4000, 32'h99);
		sb(1'b0, SIZE_WORD, 32'h2004_4000, '0);
		chk("data hi", q, 32'h99);
		sb(1'b0, SIZE_WORD, 32'h1000_0000, '0);
		chk("instr gone", {31'h0, e}, 32'h1);
		// manual init of bank 2 only
		apb(1'b1, CFG_OFS, 32'h0000_2004);
		repeat (2) @(posedge clock);
		chk("retain2", {26'h0, bank_retain}, 32'h5);
		apb(1'b0, CFG_OFS, '0);
		chk("start clears", q, 32'h4);
		sb(1'b0, SIZE_WORD, 32'h2000_4000, '0);
		chk("bank2 stall", {31'h0, n > 900}, 32'h1);
		chk("bank2 zero", q, 32'h0);
		st(32'h5);
		// restart then abort
		apb(1'b1, CFG_OFS, 32'h0000_2004);
		st(32'h1);
		apb(1'b1, CFG_OFS, 32'h0000_8004);
		apb(1'b0, CFG_OFS, '0);
		chk("abort clears", q, 32'h4);
		sb(1'b0, SIZE_WORD, 32'h2000_4000, '0);
		chk("after abort", 32'(n), 32'd2);
		repeat (1100) @(posedge clock);
		st(32'h1);
		// armed init of bank 3 on hibernate exit
		apb(1'b1, CFG_OFS, 32'h0000_4008);
		@(posedge clock);
		hib_exit <= 1'b1;
		@(posedge clock);
		hib_exit <= 1'b0;
		sb(1'b0, SIZE_WORD, 32'h2004_0000, '0);
		chk("auto stall", {31'h0, n > 900}, 32'h1);
		st(32'h9);
		// cache enable sequence, first without the key
		apb(1'b0, CACHE_STATE_OFS, '0);
		chk("cache state", q, 32'h0);
		apb(1'b1, CACHE_SETUP_OFS, 32'h1);
		repeat (2) @(posedge clock);
		chk("no key", {31'h0, icache_on}, 32'h0);
		apb(1'b1, CACHE_KEY_OFS, CACHE_KEY);
		apb(1'b0, CACHE_KEY_OFS, '0);
		chk("key read", q, 32'h0);
		apb(1'b1, CACHE_SETUP_OFS, 32'h1);
		repeat (2) @(posedge clock);
		chk("cache on", {31'h0, icache_on}, 32'h1);
		sb(1'b0, SIZE_WORD, 32'h2004_7000, '0);
		chk("bank5 err", {31'h0, e}, 32'h1);
		cache_req <= '{1'b1, 1'b1, 10'h3, 32'hcafe_f00d};
		@(posedge clock);
		cache_req <= '{1'b1, 1'b0, 10'h3, 32'h0};
		@(posedge clock);
		cache_req <= '0;
		@(posedge clock);
		chk("cache word", cache_rdata, 32'hcafe_f00d);
		apb(1'b0, 12'h100, '0);
		chk("unmapped", {31'h0, e}, 32'h1);
		wrap_up();
	end
endmodule : tb
